// ===== src/frd_map.vh
// Opcode patterns, field positions and flag positions of the file-register op decoder
`ifndef FRD_MAP_VH
`define FRD_MAP_VH
// Opcode upper six bits (instr[15:10])
`define FRD_OP_ADD_WITH_CARRY 6'h08
`define FRD_OP_DEC_SKIP_ZERO 6'h0B
`define FRD_OP_INC_SKIP_ZERO 6'h0F
`define FRD_OP_INC_SKIP_NONZERO 6'h12
`define FRD_OP_DEC_SKIP_NONZERO 6'h13
`define FRD_OP_COMPARE_GROUP 6'h18
// Compare sub-op in instr[9:9]/[10:9] for the 0110 0xxa group (instr[15:9])
`define FRD_CMP_LESS 7'h30
`define FRD_CMP_EQUAL 7'h31
`define FRD_CMP_GREATER 7'h32
// Field positions in the instruction word
`define FRD_BIT_DEST 9
`define FRD_BIT_ACCESS 8
// Status flag positions
`define FRD_FLAG_C 0
`define FRD_FLAG_DC 1
`define FRD_FLAG_Z 2
`define FRD_FLAG_OV 3
`define FRD_FLAG_N 4
// Access-bank split point and reset values
`define FRD_ACCESS_SPLIT 8'h80
`define FRD_ACCESS_HIGH_BANK 4'hF
`define FRD_RESET_STATUS 5'h00
`endif

// ===== src/frd_file_register_op_decoder.v
// Decode-and-execute logic for the file-register add, compare-skip and inc/dec-skip instructions
`include "frd_map.vh"

// What this block does
// - 0010 00da adds working register, carry and file byte; updates C, DC, Z, OV, N
// - 0110 001a skips next instruction when file byte equals working register; flags kept
// - 0110 010a skips next instruction when file byte exceeds working register; flags kept
// - 0110 000a skips next instruction when file byte is below working register
// - 0010 11da decrements file byte, stores it, skips when result is zero
// - 0100 11da decrements file byte, stores it, skips when result is non-zero
// - 0011 11da increments file byte, stores it, skips when result is zero
// - 0100 10da increments file byte, stores it, skips when result is non-zero
// - A taken skip adds a second cycle executed as a no-operation
// - Skipping a two-word instruction costs a third no-operation cycle
module frd_file_register_op_decoder #(
   parameter DATA_W = 8
) (
   input wire sys_clk,
   input wire rstn,
   input wire instr_valid,
   input wire [15:0] instr,
   input wire next_is_two_word,
   input wire [3:0] bank_select,
   input wire [DATA_W-1:0] working_register,
   input wire [DATA_W-1:0] file_rdata,
   input wire [4:0] status_in,
   output reg [11:0] file_addr,
   output reg file_we,
   output reg [DATA_W-1:0] file_wdata,
   output reg working_register_we,
   output reg [DATA_W-1:0] working_register_wdata,
   output reg status_we,
   output reg [4:0] status_out,
   output reg skip_taken,
   output reg nop_cycle,
   output reg busy,
   output reg op_done
);

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_EXEC = 3'b010;
   localparam ST_NOP = 3'b100;

   // Sequencer state, NOP countdown and held instruction
   reg [2:0] state;
   reg [2:0] next_state;
   reg [1:0] nop_left;
   reg [15:0] op_word;
   reg two_word_latch;

   // ------------------------------------------------------------
   // Address forming
   // ------------------------------------------------------------

   // Forms the full 12-bit file address from a and f
   function [11:0] full_addr;
      input [15:0] w;
      input [3:0] bsr;
      begin
         if (w[`FRD_BIT_ACCESS]) begin
            full_addr = {bsr, w[7:0]};
         end else if (w[7:0] < `FRD_ACCESS_SPLIT) begin
            full_addr = {4'h0, w[7:0]};
         end else begin
            full_addr = {`FRD_ACCESS_HIGH_BANK, w[7:0]};
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Combinational execute
   // ------------------------------------------------------------
   wire [5:0] opc = op_word[15:10];
   wire [6:0] opc7 = op_word[15:9];
   wire dest = op_word[`FRD_BIT_DEST];
   // Adder with carry in, nibble carry and the inc/dec results
   wire [DATA_W:0] add_sum = {1'b0, file_rdata} + {1'b0, working_register} + {{DATA_W{1'b0}}, status_in[`FRD_FLAG_C]};
   wire [4:0] nib_sum = {1'b0, file_rdata[3:0]} + {1'b0, working_register[3:0]} + {4'h0, status_in[`FRD_FLAG_C]};
   wire [DATA_W-1:0] dec_val = file_rdata - {{(DATA_W-1){1'b0}}, 1'b1};
   wire [DATA_W-1:0] inc_val = file_rdata + {{(DATA_W-1){1'b0}}, 1'b1};

   // Decode results for the execute cycle
   reg is_known;
   reg do_write;
   reg do_skip;
   reg do_status;
   reg [DATA_W-1:0] result;
   reg [4:0] next_status;

   // Decode and evaluate the held instruction
   always @* begin
      is_known = 1'b1;
      do_write = 1'b0;
      do_skip = 1'b0;
      do_status = 1'b0;
      result = file_rdata;
      next_status = status_in;
      if (opc == `FRD_OP_ADD_WITH_CARRY) begin
         result = add_sum[DATA_W-1:0];
         do_write = 1'b1;
         do_status = 1'b1;
         next_status[`FRD_FLAG_C] = add_sum[DATA_W];
         next_status[`FRD_FLAG_DC] = nib_sum[4];
         next_status[`FRD_FLAG_Z] = (add_sum[DATA_W-1:0] == {DATA_W{1'b0}});
         next_status[`FRD_FLAG_OV] = (file_rdata[DATA_W-1] == working_register[DATA_W-1]) &&
            (add_sum[DATA_W-1] != file_rdata[DATA_W-1]);
         next_status[`FRD_FLAG_N] = add_sum[DATA_W-1];
      end else if (opc == `FRD_OP_DEC_SKIP_ZERO) begin
         result = dec_val;
         do_write = 1'b1;
         do_skip = (dec_val == {DATA_W{1'b0}});
      end else if (opc == `FRD_OP_DEC_SKIP_NONZERO) begin
         result = dec_val;
         do_write = 1'b1;
         do_skip = (dec_val != {DATA_W{1'b0}});
      end else if (opc == `FRD_OP_INC_SKIP_ZERO) begin
         result = inc_val;
         do_write = 1'b1;
         do_skip = (inc_val == {DATA_W{1'b0}});
      end else if (opc == `FRD_OP_INC_SKIP_NONZERO) begin
         result = inc_val;
         do_write = 1'b1;
         do_skip = (inc_val != {DATA_W{1'b0}});
      end else if (opc7 == `FRD_CMP_EQUAL) begin
         do_skip = (file_rdata == working_register);
      end else if (opc7 == `FRD_CMP_GREATER) begin
         do_skip = (file_rdata > working_register);
      end else if (opc7 == `FRD_CMP_LESS) begin
         do_skip = (file_rdata < working_register);
      end else begin
         is_known = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always @* begin
      case (state)
         ST_IDLE: begin
            next_state = instr_valid ? ST_EXEC : ST_IDLE;
         end
         ST_EXEC: begin
            next_state = (is_known && do_skip) ? ST_NOP : ST_IDLE;
         end
         ST_NOP: begin
            next_state = (nop_left == 2'd1) ? ST_IDLE : ST_NOP;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer and registered outputs
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         nop_left <= 2'd0;
         op_word <= 16'h0000;
         two_word_latch <= 1'b0;
         file_addr <= 12'h000;
         file_we <= 1'b0;
         file_wdata <= {DATA_W{1'b0}};
         working_register_we <= 1'b0;
         working_register_wdata <= {DATA_W{1'b0}};
         status_we <= 1'b0;
         status_out <= `FRD_RESET_STATUS;
         skip_taken <= 1'b0;
         nop_cycle <= 1'b0;
         busy <= 1'b0;
         op_done <= 1'b0;
      end else begin
         state <= next_state;
         file_we <= 1'b0;
         working_register_we <= 1'b0;
         status_we <= 1'b0;
         skip_taken <= 1'b0;
         op_done <= 1'b0;
         nop_cycle <= (next_state == ST_NOP);
         busy <= (next_state != ST_IDLE);
         case (state)
            ST_IDLE: begin
               if (instr_valid) begin
                  op_word <= instr;
                  two_word_latch <= next_is_two_word;
                  file_addr <= full_addr(instr, bank_select);
               end
            end
            ST_EXEC: begin
               op_done <= 1'b1;
               if (is_known && do_write) begin
                  // Destination select
                  file_we <= dest;
                  working_register_we <= ~dest;
                  file_wdata <= result;
                  working_register_wdata <= result;
               end
               if (is_known && do_status) begin
                  status_we <= 1'b1;
                  status_out <= next_status;
               end
               if (is_known && do_skip) begin
                  skip_taken <= 1'b1;
                  nop_left <= two_word_latch ? 2'd2 : 2'd1;
               end
            end
            ST_NOP: begin
               nop_left <= nop_left - 2'd1;
            end
            default: begin
               nop_left <= 2'd0;
            end
         endcase
      end
   end

endmodule

// ===== tb/frd_op_asserts.sv
// Port checker for the file-register op decoder
`include "frd_map.vh"
module frd_op_asserts #(
   parameter DATA_W = 8
) (
   input wire sys_clk,
   input wire rstn,
   input wire instr_valid,
   input wire [15:0] instr,
   input wire next_is_two_word,
   input wire [3:0] bank_select,
   input wire [DATA_W-1:0] working_register,
   input wire [DATA_W-1:0] file_rdata,
   input wire [4:0] status_in,
   input wire [11:0] file_addr,
   input wire file_we,
   input wire [DATA_W-1:0] file_wdata,
   input wire working_register_we,
   input wire [DATA_W-1:0] working_register_wdata,
   input wire status_we,
   input wire [4:0] status_out,
   input wire skip_taken,
   input wire nop_cycle,
   input wire busy,
   input wire op_done
);
   reg [20:0] cap;
   wire take = instr_valid && !busy;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   // Hold taken word, bank and two-word hint
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         cap <= 21'h0;
      else if (take)
         cap <= {next_is_two_word, bank_select, instr};
   end
   AST_TAKE_BUSY: assert property (take |=> busy && !op_done) else $error("no busy after take");
   AST_DONE_LAT: assert property (take |=> ##1 op_done) else $error("late op_done");
   AST_DONE_PULSE: assert property (op_done |=> !op_done) else $error("op_done too long");
   AST_STATUS_ADD: assert property (status_we |-> op_done && cap[15:10] == `FRD_OP_ADD_WITH_CARRY) else $error("status");
   AST_CMP_NO_WR: assert property (op_done && cap[15:12] == 4'h6 |-> !file_we && !working_register_we) else $error("cmp wr");
   AST_DEST: assert property (file_we || working_register_we |-> file_we == cap[9] && working_register_we == !cap[9]) else $error("dest");
   AST_ADDR: assert property (op_done |-> file_addr == (cap[8] ? {cap[19:16], cap[7:0]} : {{4{cap[7]}}, cap[7:0]}))
      else $error("addr");
   AST_SKIP_NOP: assert property (skip_taken |-> op_done && nop_cycle && busy) else $error("skip nop");
   AST_ONE_WORD: assert property (skip_taken && !cap[20] |=> !busy && !nop_cycle) else $error("one word");
   AST_TWO_WORD: assert property (skip_taken && cap[20] |=> busy && nop_cycle ##1 !busy) else $error("two word");
endmodule
bind frd_file_register_op_decoder frd_op_asserts #(.DATA_W(DATA_W)) chk_u (.sys_clk(sys_clk), .rstn(rstn),
   .instr_valid(instr_valid), .instr(instr), .next_is_two_word(next_is_two_word), .bank_select(bank_select),
   .working_register(working_register), .file_rdata(file_rdata), .status_in(status_in), .file_addr(file_addr),
   .file_we(file_we), .file_wdata(file_wdata), .working_register_we(working_register_we), .working_register_wdata(working_register_wdata), .status_we(status_we),
   .status_out(status_out), .skip_taken(skip_taken), .nop_cycle(nop_cycle), .busy(busy), .op_done(op_done));

// ===== tb/tb.sv
// Self-checking bench for the file-register op decoder
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rstn = 0, instr_valid = 0, next_is_two_word = 0, c, sk, wr;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bank_select = 4'h0;
   logic [7:0] working_register = 8'h00, file_rdata = 8'h00, w, f, res;
   logic [4:0] status_in = 5'h00;
   logic [8:0] s;
   logic [31:0] r = 32'hC096;
   // Eight block opcodes, then one word the block does not decode
   logic [15:0] ops [9] = '{16'h2000, 16'h6200, 16'h6400, 16'h6000, 16'h2C00, 16'h4C00, 16'h3C00, 16'h4800,
      16'h2400};
   wire [11:0] file_addr;
   wire [7:0] file_wdata, working_register_wdata;
   wire [4:0] status_out;
   wire file_we, working_register_we, status_we, skip_taken, nop_cycle, busy, op_done;
   int n_fail = 0, compares = 0, k, nops;
   frd_file_register_op_decoder dut_u (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
      .instr(instr), .next_is_two_word(next_is_two_word), .bank_select(bank_select),
      .working_register(working_register), .file_rdata(file_rdata), .status_in(status_in), .file_addr(file_addr),
      .file_we(file_we), .file_wdata(file_wdata), .working_register_we(working_register_we), .working_register_wdata(working_register_wdata),
      .status_we(status_we), .status_out(status_out), .skip_taken(skip_taken), .nop_cycle(nop_cycle),
      .busy(busy), .op_done(op_done));
   // Free-running clock
   always #4 sys_clk = ~sys_clk;
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog
   initial begin
      #60us;
      n_fail++;
      report_and_stop;
   end
   // Random instructions from all eight opcodes and one unknown word against the model
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 rstn = 1;
      for (int i = 0; i < 400; i++) begin
         r = nx(r);
         k = i % 9;
         f = r[20] ? (r[21] ? 8'hFF : 8'h01) : r[31:24];
         w = r[22] ? f : r[15:8];
         c = r[23];
         instr = ops[k] | {6'h00, (k >= 1 && k <= 3) ? 1'b0 : r[9], r[8], r[7:0]};
         {instr_valid, file_rdata, working_register, bank_select, next_is_two_word} = {1'b1, f, w, r[27:24], r[5]};
         status_in = {r[4:1], c};
         @(posedge sys_clk);
         #1 instr_valid = 0;
         @(posedge sys_clk);
         #1;
         s = {1'b0, w} + f + c;
         res = (k == 0) ? s[7:0] : (k >= 6) ? f + 8'h01 : f - 8'h01;
         sk = k == 1 ? f == w : k == 2 ? f > w : k == 3 ? f < w : (k == 4 || k == 6) ? res == 0 :
            (k == 5 || k == 7) && res != 0;
         wr = (k == 0 || (k >= 4 && k <= 7));
         chk(op_done, 1'b1);
         chk(file_addr, instr[8] ? {bank_select, instr[7:0]} : {{4{instr[7]}}, instr[7:0]});
         chk(skip_taken, sk);
         chk({busy, nop_cycle}, {2{sk}});
         chk({file_we, working_register_we}, wr ? (instr[9] ? 2'b10 : 2'b01) : 2'b00);
         if (wr) chk(instr[9] ? file_wdata : working_register_wdata, res);
         chk(status_we, k == 0);
         if (k == 0) chk(status_out, {s[7], ~(w[7] ^ f[7]) & (s[7] ^ w[7]), s[7:0] == 0, (w[3:0] + f[3:0] + c) > 15, s[8]});
         nops = 0;
         while (busy === 1'b1 && nops < 5) begin
            @(posedge sys_clk);
            #1 nops++;
            chk(nop_cycle, busy);
         end
         chk(16'(nops), sk ? (next_is_two_word ? 16'h0002 : 16'h0001) : 16'h0000);
      end
      report_and_stop;
   end
endmodule
